// ---- src/dopo_pkg.sv ----
// package for the delayed one-shot pulse output channel
// assumes a single 25 MHz module clock; all times are tick counts
`default_nettype none
package dopo_pkg;
    // module clock
    localparam int unsigned CLK_HZ          = 25_000_000;
    // time base periods in microseconds, as printed (0.1 ms and 1 ms)
    localparam int unsigned TB_FINE_US      = 100;
    localparam int unsigned TB_COARSE_US    = 1000;
    // clock cycles per tick, derived from the rate
    localparam int unsigned TB_FINE_CYC     = CLK_HZ / 1_000_000 * TB_FINE_US;
    localparam int unsigned TB_COARSE_CYC   = CLK_HZ / 1_000_000 * TB_COARSE_US;
    localparam int unsigned TB_CNT_W        = 15;
    // least usable duration counts per time base
    localparam logic [15:0] MIN_DUR_FINE    = 16'h0002;
    localparam logic [15:0] MIN_DUR_COARSE  = 16'h0001;
    // on-delay limits: 0.2 ms floor in fine ticks, 65.535 s ceiling in coarse ticks
    localparam logic [15:0] MIN_DLY_FINE    = 16'h0002;
    localparam logic [15:0] MAX_DLY_COARSE  = 16'hffff;
    // factor weighting divisor (0.1)
    localparam int unsigned FACTOR_DIV      = 10;
    // sequence counter limits
    localparam logic [3:0]  SEQ_MAX_PLAIN   = 4'h1;
    localparam logic [3:0]  SEQ_MAX_GATED   = 4'hf;
    // reset values of configuration
    localparam logic        TB_DEFAULT      = 1'b0;
    localparam logic        GATE_DEFAULT    = 1'b0;
    localparam logic [15:0] DLY_PAR_DEFAULT = 16'h0000;

    // sequence states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_DELAY = 3'b010,
        ST_PULSE = 3'b100
    } dopo_state_t;
endpackage
`default_nettype wire

// ---- src/dopo_channel.sv ----
// one channel of a delayed one-shot pulse generator
// assumes all inputs synchronous to core_clk_i and config held stable while a sequence runs
// Function
// - echo output shows whether a start request is pending
// - gate select picks plain input or hardware gate, default plain
// - with gate, sequence begins at first gate rising edge while requested
// - gate rising edges during a running sequence are ignored
// - while request stays set, each new gate edge after a sequence ends starts another
// - start event begins on-delay timing and sets running status
// - after delay, output high for duration, then low and running cleared
// - dropping request during delay or pulse aborts at once
// - fine base gives 0.2 ms to 6.5535 s in 0.1 ms steps
// - coarse base gives 1 ms to 65.535 s in 1 ms steps
// - duration is a 16-bit count times the time base
// - duration change while running keeps going to the new end
// - new duration below elapsed time ends sequence and sets pulse fault
// - pulse fault stays set until next sequence start clears it
// - short interface on-delay is a 16-bit parameter times time base
// - short interface effective delay is factor times 0.1 times parameter
// - factor change mid-sequence applies only from next start
// - isochronous synchronisation leaves behaviour unchanged
// - time base selects 0.1 ms or 1 ms, default fine; delay default 0
// - long interface takes on-delay count directly from the controller
// - duration below minimum count gives no output pulse
// - tiny delay or zero factor means no delay; huge delay clamped
// - sequence counter counts completions, wraps at 1 plain or 15 gated
`default_nettype none
module dopo_channel
    import dopo_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    // configuration
    input  wire logic        coarse_base_i,       // 0: 0.1 ms, 1: 1 ms
    input  wire logic        hardware_gate_i,     // 1: gate pin acts as hardware gate
    input  wire logic        long_interface_i,    // 1: delay count taken directly
    input  wire logic [15:0] delay_param_i,       // configured on-delay count
    // control from the controller
    input  wire logic        sw_start_request_i,
    input  wire logic        direct_output_i,     // direct output control bit
    input  wire logic [15:0] pulse_duration_i,
    input  wire logic [7:0]  delay_factor_i,
    input  wire logic [15:0] delay_count_i,       // long interface on-delay
    // process pin
    input  wire logic        gate_input_pin_i,
    output logic             pulse_o,
    // feedback
    output logic             sequence_running_o,
    output logic             start_request_echo_o,
    output logic             pulse_fault_o,
    output logic             gate_level_o,
    output logic             pulse_level_o,
    output logic [3:0]       sequence_counter_o
);

    // scale a count by a time base to fine ticks (used for the delay floor test)
    // wide enough for a clamped fine delay, so the floor test never sees a wrapped value
    function automatic logic [23:0] to_fine(input logic [19:0] cnt, input logic coarse);
        logic [23:0] r;
        r = {4'h0, cnt};
        if (coarse) begin
            r = 24'(cnt * 20'(TB_COARSE_US / TB_FINE_US));
        end
        return r;
    endfunction

    // sequence state
    dopo_state_t         state_ff;
    dopo_state_t         nxt_state;
    // divider and phase timing, elapsed and delay 20 bits to hold a clamped fine delay
    logic [TB_CNT_W-1:0] tb_cnt_ff;
    logic                tick;
    logic [19:0]         elapsed_ff;
    logic [19:0]         delay_ff;
    // edge memories and sticky status
    logic                req_ff;
    logic                gate_ff;
    logic                armed_ff;
    logic                fault_ff;
    logic [3:0]          seq_ff;
    // decoded strobes
    logic                pulse_ff;
    logic                start;
    logic                gate_rise;
    logic [19:0]         eff_delay;
    logic                dur_ok;
    logic                done;
    logic                shrink;

    // time base tick
    // the divider free-runs, so the first tick of a sequence may come early by
    // up to one tick period; the trade is one shared divider and no restart logic
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tb_cnt_ff <= '0;
        end else if (tick) begin
            tb_cnt_ff <= '0;
        end else begin
            tb_cnt_ff <= tb_cnt_ff + 1'b1;
        end
    end

    assign tick = coarse_base_i ? (tb_cnt_ff == TB_CNT_W'(TB_COARSE_CYC - 1))
                                : (tb_cnt_ff == TB_CNT_W'(TB_FINE_CYC - 1));

    always_comb begin
        logic [31:0] prod;
        logic [31:0] lim;
        logic [23:0] fine;
        // the ceiling is the same time in both bases, so the fine base needs ten
        // times the count; a 16-bit delay would cut it at a tenth of that
        lim       = coarse_base_i ? 32'(MAX_DLY_COARSE)
                                  : 32'(MAX_DLY_COARSE) * 32'(TB_COARSE_US / TB_FINE_US);
        prod      = '0;
        fine      = '0;
        eff_delay = '0;
        if (long_interface_i) begin
            eff_delay = {4'h0, delay_count_i};
        end else begin
            prod = 32'(delay_param_i) * 32'(delay_factor_i) / 32'(FACTOR_DIV);
            if (prod > lim) begin
                prod = lim;
            end
            eff_delay = prod[19:0];
        end
        fine = to_fine(eff_delay, coarse_base_i);
        if (fine < 24'(MIN_DLY_FINE)) begin
            eff_delay = '0;
        end
    end

    assign dur_ok = coarse_base_i ? (pulse_duration_i >= MIN_DUR_COARSE)
                                  : (pulse_duration_i >= MIN_DUR_FINE);

    // edge memories for request and gate
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_ff  <= 1'b0;
            gate_ff <= 1'b0;
        end else begin
            req_ff  <= sw_start_request_i;
            gate_ff <= gate_input_pin_i;
        end
    end

    assign gate_rise = gate_input_pin_i & ~gate_ff;

    // armed means a rising request edge is waiting to be used (plain mode)
    // fresh start required after abort or finish
    // a start consumes the edge before it may arm, otherwise a held request
    // would restart the channel on the first idle cycle after a finish
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            armed_ff <= 1'b0;
        end else if (!sw_start_request_i) begin
            armed_ff <= 1'b0;
        end else if (start) begin
            armed_ff <= 1'b0;
        end else if (!req_ff && !direct_output_i) begin
            armed_ff <= 1'b1;
        end
    end

    // start needs request edge (plain) or gate edge with request held (gated), direct control low
    always_comb begin
        start = 1'b0;
        if (state_ff == ST_IDLE && sw_start_request_i && !direct_output_i) begin
            if (hardware_gate_i) begin
                start = gate_rise;
            end else begin
                start = armed_ff | ~req_ff;
            end
        end
    end

    // shrink below elapsed is a fault
    assign shrink = (state_ff == ST_PULSE) && (20'(pulse_duration_i) < elapsed_ff);
    assign done   = (state_ff == ST_PULSE) && tick
                    && (elapsed_ff + 20'h00001 >= 20'(pulse_duration_i));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start && dur_ok) begin
                    nxt_state = (eff_delay == 20'h00000) ? ST_PULSE : ST_DELAY;
                end else if (start) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_DELAY: begin
                if (!sw_start_request_i) begin
                    nxt_state = ST_IDLE;
                end else if (tick && elapsed_ff + 20'h00001 >= delay_ff) begin
                    nxt_state = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (!sw_start_request_i || shrink || done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // elapsed tick counter, restarted on each phase change
    // delay latched at start
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            elapsed_ff <= '0;
            delay_ff   <= 20'(DLY_PAR_DEFAULT);
        end else if (nxt_state != state_ff) begin
            elapsed_ff <= '0;
            if (state_ff == ST_IDLE) begin
                delay_ff <= eff_delay;
            end
        end else if (tick && state_ff != ST_IDLE && elapsed_ff != 20'hfffff) begin
            elapsed_ff <= elapsed_ff + 20'h00001;
        end
    end

    // duration in ticks of the base
    // output rises in start cycle when no delay
    always_comb begin
        pulse_ff = (state_ff == ST_PULSE) && sw_start_request_i && !shrink;
        if (state_ff == ST_IDLE && start && dur_ok && eff_delay == 20'h00000) begin
            pulse_ff = 1'b1;
        end
    end

    // fault set on shrink; set wins
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault_ff <= 1'b0;
        end else if (shrink && sw_start_request_i) begin
            fault_ff <= 1'b1;
        end else if (start) begin
            fault_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seq_ff <= '0;
        end else if (done && sw_start_request_i) begin
            if (seq_ff >= (hardware_gate_i ? SEQ_MAX_GATED : SEQ_MAX_PLAIN)) begin
                seq_ff <= '0;
            end else begin
                seq_ff <= seq_ff + 4'h1;
            end
        end
    end

    // no isochronous dependency in any path
    assign start_request_echo_o = sw_start_request_i;
    // running falls with the request in the same cycle, like the pulse, so an
    // abort shows at once on both
    assign sequence_running_o   = ((state_ff != ST_IDLE) && sw_start_request_i)
                                  || (start && dur_ok);
    assign pulse_o              = pulse_ff;
    assign pulse_level_o        = pulse_ff;
    assign gate_level_o         = gate_ff;
    assign pulse_fault_o        = fault_ff;
    assign sequence_counter_o   = seq_ff;

endmodule
`default_nettype wire

// ---- bench/dopo_channel_assertions.sv ----
// port checker for one pulse output channel
// assumes it is bound into dopo_channel, single clock domain
`default_nettype none
module dopo_channel_assertions (
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    input wire logic       sw_start_request_i,
    input wire logic       direct_output_i,
    input wire logic       pulse_o,
    input wire logic       sequence_running_o,
    input wire logic       start_request_echo_o,
    input wire logic       pulse_fault_o,
    input wire logic       pulse_level_o,
    input wire logic [3:0] sequence_counter_o
);
    // one clock, so one default for all checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_echo; start_request_echo_o == sw_start_request_i; endproperty
    a_echo: assert property (p_echo) else $error("echo wrong");
    property p_abort; !sw_start_request_i |-> !pulse_o && !sequence_running_o; endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_pulse_run; pulse_o |-> sequence_running_o; endproperty
    a_pulse_run: assert property (p_pulse_run) else $error("pulse idle");
    property p_level; pulse_level_o == pulse_o; endproperty
    a_level: assert property (p_level) else $error("level wrong");
    property p_start; $rose(sequence_running_o) |-> sw_start_request_i && !direct_output_i;
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_fault_clr; $rose(sequence_running_o) |=> !pulse_fault_o; endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault kept");
    // an abort must never be counted as a completion
    property p_cnt; $changed(sequence_counter_o) |-> $past(sequence_running_o) &&
        !sequence_running_o && sw_start_request_i; endproperty
    a_cnt: assert property (p_cnt) else $error("count wrong");
    property p_fault_set; $rose(pulse_fault_o) |-> !sequence_running_o && !pulse_o; endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault run");
endmodule
bind dopo_channel dopo_channel_assertions u_chk (.core_clk_i, .rst_b_i,
    .sw_start_request_i, .direct_output_i, .pulse_o, .sequence_running_o,
    .start_request_echo_o, .pulse_fault_o, .pulse_level_o, .sequence_counter_o);
`default_nettype wire

// ---- bench/dopo_ctl_model.sv ----
// controller model owning the start request and direct output bits
// assumes the bench calls go and halt from one process
`default_nettype none
module dopo_ctl_model (
    input  wire logic clk_i,
    output logic      req_o,
    output logic      direct_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_o = 1'b0;
        direct_o = 1'b0;
    end
    task automatic go();
        @(posedge clk_i);
        direct_o <= 1'b0;
        req_o <= 1'b1;
    endtask
    // a raise with direct control set must not start
    task automatic go_direct();
        @(posedge clk_i);
        direct_o <= 1'b1;
        req_o <= 1'b1;
    endtask
    // dropping the request also aborts a running sequence
    task automatic halt();
        @(posedge clk_i);
        req_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- bench/dopo_channel_tb.sv ----
// self-checking bench for dopo_channel
// assumes the checker is bound in and the controller model drives the request
`default_nettype none
module dopo_channel_tb
    import dopo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, cb = 1'b0, hg = 1'b0, li = 1'b0, gate = 1'b0;
    logic [15:0] dpar = 16'h0000, dur = 16'h0002, dcnt = 16'h0000;
    logic [7:0]  fac = 8'h00;
    logic        req, dir, pls, srun, echo, flt, glv, plv;
    logic [3:0]  cnt;
    int          mismatches = 0, comparisons = 0, mcnt = 0;
    always #20 clk = ~clk;
    dopo_ctl_model u_ctl (.clk_i(clk), .req_o(req), .direct_o(dir));
    dopo_channel u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .coarse_base_i(cb),
        .hardware_gate_i(hg), .long_interface_i(li), .delay_param_i(dpar),
        .sw_start_request_i(req), .direct_output_i(dir), .pulse_duration_i(dur),
        .delay_factor_i(fac), .delay_count_i(dcnt), .gate_input_pin_i(gate),
        .pulse_o(pls), .sequence_running_o(srun), .start_request_echo_o(echo),
        .pulse_fault_o(flt), .gate_level_o(glv), .pulse_level_o(plv),
        .sequence_counter_o(cnt));
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    // measure one sequence in ticks; the first tick may be partial
    task automatic run(int d, int n);
        int t, c;
        t = cb ? TB_COARSE_CYC : TB_FINE_CYC;
        c = 0;
        while (srun !== 1'b1 && c < 50) begin @(negedge clk); c++; end
        chk("run", 16'h0001, {15'h0000, srun});
        c = 0;
        while (pls !== 1'b1 && c < 70000) begin @(negedge clk); c++; end
        // one cycle off: the start cycle itself is counted, the first tick may be partial
        chk("dly", 16'(d), 16'((c + t - 2) / t));
        c = 0;
        while (srun === 1'b1 && c < 70000) begin @(negedge clk); c++; end
        chk("dur", 16'(n), 16'((c + t - 2) / t));
        mcnt = (mcnt + 1 >= (hg ? 16 : 2)) ? 0 : mcnt + 1;
        chk("cnt", 16'(mcnt), {12'h000, cnt});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // watchdog sized just above the expected length of the whole test
    initial begin
        #(95000 * 40);
        mismatches++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h82654961));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        gate <= 1'b1;
        @(negedge clk);
        chk("rst", 16'h0000, {flt, srun, pls, cnt});
        @(negedge clk);
        chk("pin", 16'h0001, {srun, glv});
        u_ctl.go();
        run(0, 2);
        u_ctl.halt();
        dur <= 16'h0001;
        u_ctl.go();
        repeat (20) @(negedge clk);
        chk("short", 16'h0001, {srun, pls, cnt});
        u_ctl.halt();
        dur <= 16'h0002;
        u_ctl.go_direct();
        repeat (20) @(negedge clk);
        chk("direct", 16'h0001, {srun, pls, cnt});
        u_ctl.halt();
        dpar <= 16'h0003;
        fac <= 8'h0a;
        u_ctl.go();
        @(posedge clk) fac <= 8'($urandom);
        run(3, 2);
        u_ctl.halt();
        li <= 1'b1;
        dcnt <= 16'h0002;
        u_ctl.go();
        run(2, 2);
        u_ctl.halt();
        li <= 1'b0;
        fac <= 8'h00;
        dur <= 16'h0004;
        u_ctl.go();
        repeat (3000) @(negedge clk);
        u_ctl.halt();
        @(negedge clk);
        chk("abort", 16'h0001, {srun, pls, cnt});
        u_ctl.go();
        repeat (6000) @(negedge clk);
        @(posedge clk) dur <= 16'h0001;
        repeat (3) @(negedge clk);
        chk("shrink", 16'h0041, {flt, srun, pls, cnt});
        u_ctl.halt();
        dur <= 16'h0002;
        u_ctl.go();
        @(posedge clk) dur <= 16'h0003;
        run(0, 3);
        chk("fault", 16'h0000, {15'h0000, flt});
        u_ctl.halt();
        hg <= 1'b1;
        gate <= 1'b0;
        u_ctl.go();
        repeat (50) @(negedge clk);
        chk("gate", 16'h0000, {15'h0000, srun});
        @(posedge clk) gate <= 1'b1;
        fork
            run(0, 3);
            begin
                repeat ($urandom_range(100, 4000)) @(posedge clk);
                gate <= 1'b0;
                @(posedge clk) gate <= 1'b1;
            end
        join
        repeat (20) @(negedge clk);
        chk("again", 16'h0000, {15'h0000, srun});
        @(posedge clk) gate <= 1'b0;
        @(posedge clk) gate <= 1'b1;
        run(0, 3);
        u_ctl.halt();
        hg <= 1'b0;
        cb <= 1'b1;
        dur <= 16'h0001;
        u_ctl.go();
        run(0, 1);
        end_of_test();
    end
endmodule
`default_nettype wire
